/* rtl/uesf_endpoint_status.sv */
// endpoint status flags, bank tracking, byte count and dma descriptor start
`timescale 1ns/1ns
`default_nettype none
module uesf_endpoint_status #(
  parameter int BANKS_MAX = 3
) (
  input  wire logic               clk_i,            // 20 MHz system clock
  input  wire logic               rst_b_i,          // async reset, active low
  input  wire logic [5:0]         addr_i,           // register byte address
  input  wire logic [31:0]        wdata_i,          // write data
  input  wire logic               wr_i,             // write strobe
  input  wire logic               rd_i,             // read strobe
  output logic [31:0]             rdata_o,          // read data, cycle after rd_i
  input  wire uesf_pkg::uesf_evt_t ev_i,            // usb engine events
  input  wire logic               pkt_req_i,        // endpoint asks for dma transfer
  input  wire logic               dma_done_i,       // channel reached end of buffer
  output logic                    force_stall_o,    // engine answers stall
  output logic                    ep_enabled_o,     // endpoint enabled
  output logic                    dma_fetch_o,      // pulse: fetch descriptor
  output logic [31:0]             dma_fetch_addr_o  // descriptor base address
);
  if (BANKS_MAX < 1 || BANKS_MAX > 3) begin : g_chk
    $error("BANKS_MAX must be 1 to 3");
  end

  logic rst_meta, rst_n;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // decoded bus accesses
  logic wr_cfg, wr_set, wr_clr, wr_rst, wr_en, wr_dnext, wr_dbuf, wr_dctl, wr_fifo, rd_fifo;
  assign wr_cfg   = wr_i && addr_i == uesf_pkg::ADDR_CONFIG;
  assign wr_set   = wr_i && addr_i == uesf_pkg::ADDR_CTRL_SET;
  assign wr_clr   = wr_i && addr_i == uesf_pkg::ADDR_CLR_STAT;
  assign wr_rst   = wr_i && addr_i == uesf_pkg::ADDR_EP_RESET && wdata_i[0];
  assign wr_en    = wr_i && addr_i == uesf_pkg::ADDR_EP_ENABLE;
  assign wr_dnext = wr_i && addr_i == uesf_pkg::ADDR_DMA_NEXT;
  assign wr_dbuf  = wr_i && addr_i == uesf_pkg::ADDR_DMA_BUF;
  assign wr_dctl  = wr_i && addr_i == uesf_pkg::ADDR_DMA_CTRL;
  assign wr_fifo  = wr_i && addr_i == uesf_pkg::ADDR_FIFO;
  assign rd_fifo  = rd_i && addr_i == uesf_pkg::ADDR_FIFO;

  // state
  logic [31:0]                cfg, next_cfg;
  logic                       en, next_en;
  logic                       fstall, next_fstall;
  logic                       setup_f, next_setup_f;
  logic                       err_flow, next_err_flow;
  logic                       stall_f, next_stall_f;
  logic                       crc_f, next_crc_f;
  logic                       nbtra_f, next_nbtra_f;
  logic                       flush_f, next_flush_f;
  logic                       nak_in_f, next_nak_in_f;
  logic                       nak_out_f, next_nak_out_f;
  logic                       dir_f, next_dir_f;
  logic [1:0]                 cur_bank, next_cur_bank;
  logic [1:0]                 wr_bank, next_wr_bank;
  logic [1:0]                 busy, next_busy;
  logic [uesf_pkg::BCNT_W-1:0] bcnt, next_bcnt;
  logic                       short_f, next_short_f;
  logic [1:0]                 valid_cnt, next_valid_cnt;
  logic                       sent_any, next_sent_any;
  logic [31:uesf_pkg::DESC_ALIGN_BITS] dnext, next_dnext;
  logic [31:0]                dbuf, next_dbuf;
  logic                       d_enb, next_d_enb;
  logic                       d_ld, next_d_ld;
  logic                       fetch, next_fetch;
  logic [31:0]                rdata, next_rdata;
  // per-bank memory of received count and toggle state
  logic [uesf_pkg::BCNT_W-1:0] bank_cnt [BANKS_MAX];
  logic                        bank_bad [BANKS_MAX];

  // configuration views
  logic [1:0]                  ep_type, nbtr, nbanks, cfg_banks;
  logic [uesf_pkg::BCNT_W-1:0] max_size;
  logic                        is_in, is_ctrl, is_iso, hb;
  assign ep_type   = cfg[uesf_pkg::CFG_TYPE_LSB +: 2];
  assign is_in     = cfg[uesf_pkg::CFG_DIR_IN];
  assign max_size  = cfg[uesf_pkg::CFG_SIZE_LSB +: uesf_pkg::BCNT_W];
  assign cfg_banks = cfg[uesf_pkg::CFG_BANKS_LSB +: 2];
  assign nbtr      = cfg[uesf_pkg::CFG_NBTR_LSB +: 2] == 2'h0 ? 2'h1
                                                       : cfg[uesf_pkg::CFG_NBTR_LSB +: 2];
  assign nbanks    = cfg_banks == 2'h0 ? 2'h1
                   : (cfg_banks > 2'(BANKS_MAX) ? 2'(BANKS_MAX) : cfg_banks);
  assign is_ctrl   = ep_type == uesf_pkg::TYPE_CTRL;
  assign is_iso    = ep_type == uesf_pkg::TYPE_ISO;
  assign hb        = is_iso && nbtr > 2'h1;

  function automatic logic [1:0] bank_after(input logic [1:0] b, input logic [1:0] n);
    logic [1:0] inc;
    inc = 2'(b + 2'h1);
    bank_after = (inc >= n) ? 2'h0 : inc;
  endfunction

  // transaction error is live: it tracks whatever bank is current
  logic transaction_error_flag;
  assign transaction_error_flag = hb && !is_in && busy != 2'h0 && bank_bad[cur_bank]; // [RULE1]

  // acceptance of bank moves
  logic tx_acc, rx_pop, out_acc, out_drop, in_pop;
  assign tx_acc   = en && is_in && wr_set && wdata_i[uesf_pkg::ST_TXRDY] && busy < nbanks;
  assign rx_pop   = en && !is_in && wr_clr && wdata_i[uesf_pkg::ST_RXRDY] && busy != 2'h0;
  assign out_acc  = en && !is_in && ev_i.out_rx && busy < nbanks;
  assign out_drop = en && !is_in && ev_i.out_rx && busy >= nbanks;
  assign in_pop   = en && is_in && ev_i.in_sent && busy != 2'h0;

  always_comb begin
    logic [1:0] nxt_cur;
    logic [uesf_pkg::BCNT_W-1:0] load_cnt;
    nxt_cur  = bank_after(cur_bank, nbanks);
    load_cnt = '0;
    next_cfg       = wr_cfg ? wdata_i : cfg;
    next_en        = wr_en ? wdata_i[0] : en;
    next_fstall    = fstall;
    next_setup_f   = setup_f;
    next_err_flow  = err_flow;
    next_stall_f   = stall_f;
    next_crc_f     = crc_f;
    next_nbtra_f   = nbtra_f;
    next_flush_f   = flush_f;
    next_nak_in_f  = nak_in_f;
    next_nak_out_f = nak_out_f;
    next_dir_f     = dir_f;
    next_cur_bank  = cur_bank;
    next_wr_bank   = wr_bank;
    next_busy      = 2'(busy + {1'b0, tx_acc || out_acc} - {1'b0, rx_pop || in_pop}); // [RULE14]
    next_bcnt      = bcnt;
    next_short_f   = short_f;
    next_valid_cnt = valid_cnt;
    next_sent_any  = sent_any;
    // software clears first; hardware sets below win in the same cycle
    if (wr_clr) begin
      if (wdata_i[uesf_pkg::ST_FSTALL]) next_fstall = 1'b0;
      if (wdata_i[uesf_pkg::ST_SETUP]) begin
        next_setup_f  = 1'b0;
        next_err_flow = 1'b0;
      end
      if (wdata_i[uesf_pkg::ST_STALL]) begin
        next_stall_f = 1'b0;
        next_nbtra_f = 1'b0;
      end
      if (wdata_i[uesf_pkg::ST_NAK_IN]) begin
        next_nak_in_f = 1'b0;
        next_flush_f  = 1'b0;
      end
      if (wdata_i[uesf_pkg::ST_NAK_OUT]) next_nak_out_f = 1'b0;
    end
    if (wr_set && wdata_i[uesf_pkg::ST_FSTALL]) next_fstall = 1'b1;
    if (en) begin
      if (ev_i.setup_rx && is_ctrl) begin
        next_setup_f = 1'b1;                                  // [RULE2]
        next_dir_f   = ev_i.setup_byte0[7];                   // [RULE13]
      end
      if (ev_i.setup_rx) next_fstall = 1'b0;                  // [RULE21]
      if (ev_i.stall_sent && fstall && !is_iso) next_stall_f = 1'b1; // [RULE5]
      if (ev_i.nak_in) next_nak_in_f = 1'b1;                  // [RULE8]
      if (ev_i.nak_out) next_nak_out_f = 1'b1;                // [RULE10]
      if (is_iso && ((is_in && ev_i.in_token && busy == 2'h0) || out_drop)) begin
        next_err_flow = 1'b1;                                 // [RULE4]
      end
      if (out_acc && is_iso) next_crc_f = ev_i.out_crc_err;  // [RULE6]
      if (in_pop) next_sent_any = 1'b1;
    end
    // byte count: fifo traffic, then bank reloads take precedence
    if (en && is_in && wr_fifo) next_bcnt = 11'(bcnt + 11'h001);        // [RULE15]
    if (en && !is_in && rd_fifo && bcnt != '0) next_bcnt = 11'(bcnt - 11'h001);
    if (tx_acc) begin
      next_cur_bank  = nxt_cur;                               // [RULE12]
      next_bcnt      = '0;                                    // [RULE16]
      next_valid_cnt = valid_cnt == 2'h3 ? valid_cnt : 2'(valid_cnt + 2'h1);
    end
    if (out_acc) next_wr_bank = bank_after(wr_bank, nbanks);
    if (rx_pop) begin
      next_cur_bank = nxt_cur;                                // [RULE12]
      if (busy > 2'h1) load_cnt = bank_cnt[nxt_cur];
      else if (out_acc) load_cnt = ev_i.out_count;
      next_bcnt    = load_cnt;                                // [RULE16]
      next_short_f = (busy > 2'h1 || out_acc) && load_cnt < max_size; // [RULE17]
    end else if (out_acc && busy == 2'h0) begin
      next_bcnt    = ev_i.out_count;
      next_short_f = ev_i.out_count < max_size;               // [RULE17]
    end
    // microframe bookkeeping for high-bandwidth iso in
    if (en && ev_i.uframe_end) begin
      if (hb && is_in) begin
        if (sent_any && valid_cnt < nbtr) next_nbtra_f = 1'b1; // [RULE7]
        if (next_busy != 2'h0) begin
          next_flush_f = 1'b1;                                // [RULE9]
          next_busy    = 2'h0;
        end
      end
      next_valid_cnt = 2'h0;
      next_sent_any  = 1'b0;
    end
    // endpoint reset or disable wipes the flags except nak_in_f and dir_f
    if (wr_rst || !next_en) begin                             // [RULE3]
      next_fstall    = 1'b0;
      next_setup_f   = 1'b0;
      next_err_flow  = 1'b0;
      next_stall_f   = 1'b0;
      next_crc_f     = 1'b0;
      next_nbtra_f   = 1'b0;
      next_flush_f   = 1'b0;
      next_nak_out_f = 1'b0;
      next_cur_bank  = 2'h0;
      next_wr_bank   = 2'h0;
      next_busy      = 2'h0;
      next_short_f   = 1'b0;
      next_valid_cnt = 2'h0;
      next_sent_any  = 1'b0;
    end
    if (wr_rst) next_bcnt = '0;                               // [RULE16]
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= uesf_pkg::CFG_RESET;
      en        <= 1'b0;
      fstall    <= 1'b0;
      setup_f   <= 1'b0;
      err_flow  <= 1'b0;
      stall_f   <= 1'b0;
      crc_f     <= 1'b0;
      nbtra_f   <= 1'b0;
      flush_f   <= 1'b0;
      nak_in_f  <= 1'b0;
      nak_out_f <= 1'b0;
      dir_f     <= 1'b0;
      cur_bank  <= 2'h0;
      wr_bank   <= 2'h0;
      busy      <= 2'h0;
      bcnt      <= '0;
      short_f   <= 1'b0;
      valid_cnt <= 2'h0;
      sent_any  <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      en        <= next_en;
      fstall    <= next_fstall;
      setup_f   <= next_setup_f;
      err_flow  <= next_err_flow;
      stall_f   <= next_stall_f;
      crc_f     <= next_crc_f;
      nbtra_f   <= next_nbtra_f;
      flush_f   <= next_flush_f;
      nak_in_f  <= next_nak_in_f;
      nak_out_f <= next_nak_out_f;
      dir_f     <= next_dir_f;
      cur_bank  <= next_cur_bank;
      wr_bank   <= next_wr_bank;
      busy      <= next_busy;
      bcnt      <= next_bcnt;
      short_f   <= next_short_f;
      valid_cnt <= next_valid_cnt;
      sent_any  <= next_sent_any;
    end
  end

  // bank memory has no reset; busy gates every read of it
  always_ff @(posedge clk_i) begin
    if (out_acc) begin
      bank_cnt[wr_bank] <= ev_i.out_count;
      bank_bad[wr_bank] <= ev_i.out_toggle_bad;
    end
  end

  // dma descriptor start: the low address bits are forced to zero
  always_comb begin
    next_dnext = wr_dnext ? wdata_i[31:uesf_pkg::DESC_ALIGN_BITS] : dnext; // [RULE19]
    next_dbuf  = wr_dbuf ? wdata_i : dbuf;
    next_d_enb = d_enb;
    next_d_ld  = d_ld;
    next_fetch = 1'b0;
    if (wr_dctl) begin
      next_d_enb = wdata_i[uesf_pkg::DMA_CHANN_ENB];
      next_d_ld  = wdata_i[uesf_pkg::DMA_LDNXT];
    end else if (d_enb && dma_done_i) begin
      next_d_enb = 1'b0;
    end else if (pkt_req_i && d_ld && !d_enb) begin
      next_fetch = 1'b1;                                      // [RULE20]
      next_d_ld  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dnext <= '0;
      dbuf  <= 32'h0000_0000;
      d_enb <= 1'b0;
      d_ld  <= 1'b0;
      fetch <= 1'b0;
    end else begin
      dnext <= next_dnext;
      dbuf  <= next_dbuf;
      d_enb <= next_d_enb;
      d_ld  <= next_d_ld;
      fetch <= next_fetch;
    end
  end

  // status word; reading it changes nothing
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[uesf_pkg::ST_SHORT] = short_f;
    status[uesf_pkg::ST_BCNT_LSB +: uesf_pkg::BCNT_W] = bcnt;
    status[uesf_pkg::ST_BUSY_LSB +: 2] = busy;
    status[uesf_pkg::ST_BANK_LSB +: 2] = is_ctrl ? {1'b0, dir_f} : cur_bank; // [RULE11]
    status[uesf_pkg::ST_NAK_OUT] = nak_out_f;
    status[uesf_pkg::ST_NAK_IN]  = (hb && is_in) ? flush_f : nak_in_f;
    status[uesf_pkg::ST_STALL]   = !is_iso ? stall_f : (is_in ? nbtra_f : crc_f);
    status[uesf_pkg::ST_SETUP]   = is_iso ? err_flow : setup_f;
    status[uesf_pkg::ST_TXRDY]   = (hb && !is_in) ? transaction_error_flag : (is_in && busy != 2'h0);
    status[uesf_pkg::ST_RXRDY]   = !is_in && busy != 2'h0;
    status[uesf_pkg::ST_FSTALL]  = fstall;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        uesf_pkg::ADDR_STATUS:    next_rdata = status;    // [RULE22]
        uesf_pkg::ADDR_CONFIG:    next_rdata = cfg;
        uesf_pkg::ADDR_EP_ENABLE: next_rdata = {31'h0, en};
        uesf_pkg::ADDR_DMA_NEXT:  next_rdata = {dnext, uesf_pkg::DESC_NEXT_OFS};
        uesf_pkg::ADDR_DMA_BUF:   next_rdata = dbuf;
        uesf_pkg::ADDR_DMA_CTRL:  next_rdata = {30'h0, d_ld, d_enb};
        default:                  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) rdata <= 32'h0000_0000;
    else        rdata <= next_rdata;
  end

  assign rdata_o          = rdata;
  assign force_stall_o    = fstall;
  assign ep_enabled_o     = en;
  assign dma_fetch_o      = fetch;
  assign dma_fetch_addr_o = {dnext, uesf_pkg::DESC_NEXT_OFS};

  // checks
  a_setup_sets_flag: assert property (en && ev_i.setup_rx && is_ctrl && !wr_rst && !wr_en
    |=> setup_f && dir_f == $past(ev_i.setup_byte0[7])) else $error("setup not captured"); // [RULE2]
  a_setup_kill_stall: assert property (en && ev_i.setup_rx && !wr_set
    |=> !fstall) else $error("force stall survived setup"); // [RULE21]
  a_reset_clears: assert property (wr_rst |=> !nak_out_f && !stall_f && !err_flow
    && cur_bank == 2'h0 && busy == 2'h0 && bcnt == '0 && !short_f) else $error("reset left flags"); // [RULE3]
  a_nak_in_set: assert property (en && ev_i.nak_in && !wr_en |=> nak_in_f)
    else $error("nak in lost"); // [RULE8]
  a_nak_out_set: assert property (en && ev_i.nak_out && !wr_en && !wr_rst |=> nak_out_f)
    else $error("nak out lost"); // [RULE10]
  a_bank_code: assert property (cur_bank != 2'h3 && busy <= nbanks)
    else $error("bank state out of range"); // [RULE11]
  a_bank_advance: assert property (tx_acc && nbanks > 2'h1 && !wr_rst
    |=> cur_bank != $past(cur_bank) && bcnt == '0) else $error("tx ready did not advance"); // [RULE12]
  a_fifo_count_up: assert property (en && is_in && wr_fifo && !wr_rst
    |=> bcnt == 11'($past(bcnt) + 11'h001)) else $error("byte count not incremented"); // [RULE15]
  a_flow_overflow: assert property (out_drop && is_iso && !wr_rst && !wr_en
    |=> err_flow) else $error("overflow not flagged"); // [RULE4]
  a_flush_uframe: assert property (en && ev_i.uframe_end && hb && is_in && busy != 2'h0
    && !tx_acc && !(in_pop && busy == 2'h1) && !wr_rst && !wr_en
    |=> flush_f && busy == 2'h0) else $error("flush missed"); // [RULE9]
  a_fetch_once: assert property (fetch |-> !d_ld && $past(pkt_req_i))
    else $error("fetch without request"); // [RULE20]
  c_setup: cover property (en && ev_i.setup_rx && is_ctrl);
  c_overflow: cover property (out_drop && is_iso);
  c_fetch: cover property (fetch);
  c_uframe_flush: cover property (ev_i.uframe_end && hb && is_in && busy != 2'h0);
endmodule
`default_nettype wire

/* rtl/uesf_pkg.sv */
// constants and carrier types for the endpoint status flag block
// Contract
// [RULE1] hb iso out: transaction error follows current bank
// [RULE2] control: valid setup sets flag, firmware clears
// [RULE3] endpoint reset or disable clears status flags; the nak in flag is kept
// [RULE4] iso underflow or overflow raises error flow
// [RULE5] stall sent after forced stall handshake
// [RULE6] iso out crc flag re-evaluated per bank
// [RULE7] hb iso in: too few validated banks flagged
// [RULE8] nak to in request sets flag, software clears
// [RULE9] hb iso in: flushed banks raise flush error
// [RULE10] nak to out or ping sets flag
// [RULE11] current bank coded 00, 01, 10 only
// [RULE12] bank advances on tx ready set, rx clear
// [RULE13] control direction from setup byte0 bit 7
// [RULE14] busy bank count from zero to three
// [RULE15] byte count up on write, down on read
// [RULE16] byte count reloads per bank, zero on reset
// [RULE17] short packet when count below max size
// [RULE18] descriptor words: next, buffer, control at 0/4/8
// [RULE19] descriptor sits on a 16-byte boundary
// [RULE20] write next address, set load bit, fetch on request
// [RULE21] received setup clears force stall request
// [RULE22] status read has no side effect
package uesf_pkg;
  // register byte addresses
  localparam logic [5:0] ADDR_STATUS    = 6'h00;
  localparam logic [5:0] ADDR_CONFIG    = 6'h04;
  localparam logic [5:0] ADDR_CTRL_SET  = 6'h08;
  localparam logic [5:0] ADDR_CLR_STAT  = 6'h0c;
  localparam logic [5:0] ADDR_EP_RESET  = 6'h10;
  localparam logic [5:0] ADDR_EP_ENABLE = 6'h14;
  localparam logic [5:0] ADDR_DMA_NEXT  = 6'h18;
  localparam logic [5:0] ADDR_DMA_BUF   = 6'h1c;
  localparam logic [5:0] ADDR_DMA_CTRL  = 6'h20;
  localparam logic [5:0] ADDR_FIFO      = 6'h24;
  // status word fields
  localparam int ST_SHORT    = 31;
  localparam int ST_BCNT_LSB = 20;
  localparam int ST_BUSY_LSB = 18;
  localparam int ST_BANK_LSB = 16;
  localparam int ST_NAK_OUT  = 15;
  localparam int ST_NAK_IN   = 14;
  localparam int ST_STALL    = 13;
  localparam int ST_SETUP    = 12;
  localparam int ST_TXRDY    = 11;
  localparam int ST_RXRDY    = 9;
  localparam int ST_FSTALL   = 5;
  // config word fields
  localparam int CFG_SIZE_LSB  = 0;
  localparam int CFG_TYPE_LSB  = 12;
  localparam int CFG_DIR_IN    = 14;
  localparam int CFG_NBTR_LSB  = 16;
  localparam int CFG_BANKS_LSB = 18;
  localparam logic [1:0] TYPE_CTRL = 2'h0;
  localparam logic [1:0] TYPE_ISO  = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INT  = 2'h3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // dma control bits and descriptor layout
  localparam int DMA_CHANN_ENB = 0;
  localparam int DMA_LDNXT     = 1;
  localparam logic [3:0] DESC_NEXT_OFS = 4'h0;
  localparam logic [3:0] DESC_BUF_OFS  = 4'h4;
  localparam logic [3:0] DESC_CTRL_OFS = 4'h8;
  localparam int DESC_ALIGN_BITS = 4;
  localparam int BCNT_W = 11;

  typedef struct packed {
    logic              setup_rx;       // valid setup packet received
    logic [7:0]        setup_byte0;    // request type byte of it
    logic              out_rx;         // out packet ended
    logic [BCNT_W-1:0] out_count;      // its byte count
    logic              out_crc_err;    // data crc failed
    logic              out_toggle_bad; // bad toggle sequencing in it
    logic              in_token;       // in token for this endpoint
    logic              in_sent;        // in bank sent / acked
    logic              nak_in;         // nak answered to in
    logic              nak_out;        // nak answered to out or ping
    logic              stall_sent;     // stall handshake sent
    logic              uframe_end;     // microframe ended
  } uesf_evt_t;
endpackage

/* sim/test_usb_endpoint_status_flags.sv */
// self-checking bench for the endpoint status flag block
`timescale 1ns/1ns
`default_nettype none
module test_usb_endpoint_status_flags;
  logic                clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic [5:0]          addr_i = 6'h00;
  logic [31:0]         wdata_i = 32'h0;
  logic                wr_i = 1'b0;
  logic                rd_i = 1'b0;
  logic                pkt_req_i = 1'b0;
  logic [31:0]         rdata_o;
  logic                force_stall_o;
  logic                ep_enabled_o;
  logic                dma_fetch_o;
  logic [31:0]         dma_fetch_addr_o;
  uesf_pkg::uesf_evt_t ev;
  logic [31:0]         s;
  int                  fails = 0;
  int                  cmp_count = 0;
  always #25 clk_i = ~clk_i;
  uesf_host_model host (.clk_i(clk_i), .ev_o(ev));
  uesf_endpoint_status #(.BANKS_MAX(3)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_i(ev), .pkt_req_i(pkt_req_i),
    .dma_done_i(1'b0), .force_stall_o(force_stall_o), .ep_enabled_o(ep_enabled_o),
    .dma_fetch_o(dma_fetch_o), .dma_fetch_addr_o(dma_fetch_addr_o));
  task automatic end_sim;
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
    @(posedge clk_i) wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [5:0] a);
    @(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
    @(posedge clk_i) rd_i <= 1'b0;
    #1 s = rdata_o;
  endtask
  task automatic t_control;
    wr(uesf_pkg::ADDR_CONFIG, 32'h0000_0040);
    wr(uesf_pkg::ADDR_CTRL_SET, 32'h0000_0020);
    host.hshake(1'b0, 1'b0, 1'b1);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[uesf_pkg::ST_STALL], 1'b1);
    host.setup(8'h80);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[uesf_pkg::ST_SETUP], 1'b1);
    chk(s[17:16], 2'h1);
    chk(force_stall_o, 1'b0);
    host.setup(8'h00);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[17:16], 2'h0);
    wr(uesf_pkg::ADDR_CLR_STAT, 32'h0000_1000);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[uesf_pkg::ST_SETUP], 1'b0);
  endtask
  task automatic t_nak;
    host.hshake(1'b1, 1'b1, 1'b0);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[15:14], 2'h3);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[15:14], 2'h3);
    wr(uesf_pkg::ADDR_CLR_STAT, 32'h0000_4000);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[15:14], 2'h2);
    wr(uesf_pkg::ADDR_EP_RESET, 32'h0000_0001);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[uesf_pkg::ST_NAK_OUT], 1'b0);
  endtask
  task automatic t_bulk_in;
    wr(uesf_pkg::ADDR_CONFIG, 32'h0008_6040);
    repeat (3) wr(uesf_pkg::ADDR_FIFO, 32'h0000_00a5);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[30:20], 11'h003);
    wr(uesf_pkg::ADDR_CTRL_SET, 32'h0000_0800);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[19:16], 4'h5);
    wr(uesf_pkg::ADDR_EP_RESET, 32'h0000_0001);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[30:16], 15'h0000);
  endtask
  task automatic t_iso_out;
    wr(uesf_pkg::ADDR_CONFIG, 32'h0000_1008);
    host.out_pkt(11'h004, 1'b1, 1'b0);
    rd(uesf_pkg::ADDR_STATUS);
    chk({s[31:18], s[13], s[9]}, {1'b1, 11'h004, 2'h1, 2'h3});
    rd(uesf_pkg::ADDR_FIFO);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[30:20], 11'h003);
    host.out_pkt(11'h008, 1'b0, 1'b0);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[uesf_pkg::ST_SETUP], 1'b1);
    wr(uesf_pkg::ADDR_EP_ENABLE, 32'h0);
    rd(uesf_pkg::ADDR_STATUS);
    chk({s[31], s[19:12]}, 9'h000);
    wr(uesf_pkg::ADDR_EP_ENABLE, 32'h1);
  endtask
  task automatic t_dma;
    wr(uesf_pkg::ADDR_DMA_NEXT, 32'h0000_0120); // 16-byte aligned descriptor
    wr(uesf_pkg::ADDR_DMA_CTRL, 32'h0000_0002);
    @(posedge clk_i) pkt_req_i <= 1'b1;
    @(posedge clk_i) pkt_req_i <= 1'b0;
    #1 chk({dma_fetch_o, dma_fetch_addr_o}, {1'b1, 32'h0000_0120});
    chk(dma_fetch_addr_o[3:0], uesf_pkg::DESC_NEXT_OFS); // fetch starts at the next-address word
    rd(uesf_pkg::ADDR_DMA_CTRL);
    chk(s[uesf_pkg::DMA_LDNXT], 1'b0);
  endtask
  task automatic t_hb_in;
    wr(uesf_pkg::ADDR_CONFIG, 32'h000e_5040);
    wr(uesf_pkg::ADDR_CTRL_SET, 32'h0000_0800);
    host.frame(1'b1, 1'b0);
    host.frame(1'b0, 1'b1);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[14:12], 3'h2);
    wr(uesf_pkg::ADDR_CLR_STAT, 32'h0000_2000);
    wr(uesf_pkg::ADDR_CTRL_SET, 32'h0000_0800);
    host.frame(1'b0, 1'b1);
    rd(uesf_pkg::ADDR_STATUS);
    chk({s[19:18], s[14:12]}, 5'h04);
    host.frame(1'b1, 1'b0);
    rd(uesf_pkg::ADDR_STATUS);
    chk(s[12], 1'b1);
  endtask
  task automatic t_hb_out;
    wr(uesf_pkg::ADDR_EP_RESET, 32'h0000_0001);
    wr(uesf_pkg::ADDR_CONFIG, 32'h000a_1040);
    host.out_pkt(11'h020, 1'b1, 1'b1);
    rd(uesf_pkg::ADDR_STATUS);
    chk({s[31:20], s[13], s[11]}, {1'b1, 11'h020, 2'h3});
    host.out_pkt(11'h040, 1'b0, 1'b0);
    wr(uesf_pkg::ADDR_CLR_STAT, 32'h0000_0200);
    rd(uesf_pkg::ADDR_STATUS);
    chk({s[31:16], s[13], s[11]}, {1'b0, 11'h040, 4'h5, 2'h0});
  endtask
  // watchdog: a hang is a mismatch
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(uesf_pkg::ADDR_EP_ENABLE, 32'h1);
    t_control();
    t_nak();
    t_bulk_in();
    t_iso_out();
    t_dma();
    t_hb_in();
    t_hb_out();
    end_sim();
  end
endmodule
`default_nettype wire

/* sim/uesf_host_model.sv */
// usb host side model: drives engine event pulses one cycle wide
`timescale 1ns/1ns
`default_nettype none
module uesf_host_model (
  input  wire logic          clk_i, // system clock
  output uesf_pkg::uesf_evt_t ev_o  // event pulses to the block
);
  initial ev_o = '0;
  // every pulse is launched after an edge and withdrawn at the next one
  task automatic fire(input uesf_pkg::uesf_evt_t e);
    @(posedge clk_i) ev_o <= e;
    @(posedge clk_i) ev_o <= '0;
  endtask
  task automatic setup(input logic [7:0] b0);
    uesf_pkg::uesf_evt_t e;
    e = '0;
    e.setup_rx = 1'b1; // only well-formed setup packets are sent
    e.setup_byte0 = b0;
    fire(e);
  endtask
  task automatic out_pkt(input logic [10:0] cnt, input logic crc, input logic bad);
    uesf_pkg::uesf_evt_t e;
    e = '0;
    e.out_rx = 1'b1;
    e.out_count = cnt;
    e.out_crc_err = crc;
    e.out_toggle_bad = bad;
    fire(e);
  endtask
  // an in token that takes a bank, and the microframe boundary, driven in one pulse
  task automatic frame(input logic sent, input logic uf_end);
    uesf_pkg::uesf_evt_t e;
    e = '0;
    e.in_token = sent;
    e.in_sent = sent;
    e.uframe_end = uf_end;
    fire(e);
  endtask
  task automatic hshake(input logic nin, input logic nout, input logic stl);
    uesf_pkg::uesf_evt_t e;
    e = '0;
    e.nak_in = nin; // the host issues in tokens that get naked
    e.nak_out = nout;
    e.stall_sent = stl;
    fire(e);
  endtask
endmodule
`default_nettype wire
